// file: verilog/chain_ovr_params.svh
// constants for the chaining overrun checker: timing figures and counter widths
// assumes a single 25 MHz control-unit clock
`ifndef CHAIN_OVR_PARAMS_SVH
`define CHAIN_OVR_PARAMS_SVH

`define CLK_PERIOD_NS 40
`define US_NS 1000
`define US_CYCLES (`US_NS / `CLK_PERIOD_NS)
`define US_CNT_W 9
`define US_CNT_MAX 9'h1ff
`define KEY_LEN_W 8

`define A_CMD_US 9'd70
`define A_STAT_US 9'd98
`define A_DATA_US 9'd134
`define B_CMD_US 9'd79
`define B_STAT_US 9'd88
`define B_DATA_US 9'd134
`define C_STAT_US 9'd116
`define C_DATA_US 9'd129
`define D_STAT_US 9'd116
`define E_CMD_US 9'd183
`define E_EARLY_US 9'd75
`define POSTPONE_LO_US 9'd77
`define POSTPONE_HI_US 9'd85
`define POSTPONE_AT_US 9'd86
`define STATUS_HOLD_US 4'd8

`endif

// file: verilog/chain_ovr_pkg.sv
// types for the chaining overrun checker
// assumes chain_ovr_params.svh supplies the widths
`include "chain_ovr_params.svh"

package chain_ovr_pkg;

  typedef enum logic [3:0] {
    CMD_OTHER = 4'h0,
    CMD_SEARCH_KEY = 4'h1,
    CMD_READ_ID = 4'h2,
    CMD_SEARCH_ID = 4'h3,
    CMD_READ_CKD = 4'h4,
    CMD_READ_KD = 4'h5,
    CMD_READ_DATA = 4'h6,
    CMD_WRITE_KD = 4'h7,
    CMD_WRITE_DATA = 4'h8,
    CMD_WRITE_CKD = 4'h9,
    CMD_SEARCH_HA_EQ = 4'ha,
    CMD_READ_R0 = 4'hb,
    CMD_WRITE_R0 = 4'hc,
    CMD_READ_COUNT = 4'hd
  } cmd_code_e;

  typedef enum logic [5:0] {
    CASE_NONE = 6'h01,
    CASE_A = 6'h02,
    CASE_B = 6'h04,
    CASE_C = 6'h08,
    CASE_D = 6'h10,
    CASE_E = 6'h20
  } chain_case_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_OVR = 3'h4
  } chk_state_e;

  typedef struct packed {
    cmd_code_e first;
    cmd_code_e second;
    logic [`KEY_LEN_W-1:0] key_length;
  } chain_req_s;

  typedef struct packed {
    logic cmd_tag;
    logic status_accept;
    logic data_ready;
  } chan_ev_s;

endpackage : chain_ovr_pkg

// file: verilog/us_tick.sv
// microsecond tick divider for the chaining overrun checker
// assumes one clock; restart realigns the tick phase to a reference edge
`timescale 1ns/10ps

module us_tick #(
  parameter int DIV = 25
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic restart,
  // tick out
  output logic tick
);

  logic [7:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'(DIV - 1)) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == 8'(DIV - 2));
    end
  end

endmodule : us_tick

// file: verilog/chain_overrun_checker.sv
// chaining overrun checker: times channel response after a chained ending status
// assumes channel inputs are synchronous to CLK and REF_RISE marks the status tag rise
`timescale 1ns/10ps

`include "chain_ovr_params.svh"

module chain_overrun_checker
  import chain_ovr_pkg::*;
#(
  parameter int US_DIV = `US_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // chain setup, sampled on the reference edge
  input wire logic REF_RISE,
  input wire chain_req_s CHAIN,
  // channel responses
  input wire chan_ev_s CHAN,
  // results
  output logic CMD_DETECT,
  output logic STATUS_ENABLE,
  output logic OVERRUN,
  output chain_case_e CASE_SEL,
  output logic ACTIVE
);

  ////////////////////////////////////////////////////////////////////////////
  chk_state_e state_r, state_nxt;
  chain_case_e sel_case;
  logic [`US_CNT_W-1:0] us_r;
  logic tick;
  logic cmd_d_r, cmd_rise, cmd_got_r, cmd_pend_r, cmd_det, cmd_seen_r;
  logic stat_seen_r, data_seen_r;
  logic [3:0] hold_r;
  logic bcd, in_window, late, all_met;
  logic need_cmd, need_data;
  logic [`US_CNT_W-1:0] cmd_lim, stat_lim, data_lim;

  us_tick #(.DIV(US_DIV)) u_tick (
    .clk(CLK),
    .rst(RST),
    .restart(REF_RISE),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // case selection from the two command codes
  always_comb begin
    sel_case = CASE_NONE;
    case (CHAIN.first)
      CMD_SEARCH_KEY: begin
        if (CHAIN.second inside {CMD_SEARCH_ID, CMD_READ_ID, CMD_READ_CKD}) sel_case = CASE_E;
        else if (CHAIN.second == CMD_READ_DATA) sel_case = CASE_D;
      end
      CMD_READ_ID: begin
        if (CHAIN.second inside {CMD_SEARCH_ID, CMD_READ_ID, CMD_READ_CKD}) sel_case = CASE_E;
        else if (CHAIN.second inside {CMD_READ_KD, CMD_READ_DATA}) sel_case = CASE_D;
      end
      CMD_SEARCH_ID: begin
        if (CHAIN.second inside {CMD_SEARCH_ID, CMD_READ_ID, CMD_READ_CKD}) sel_case = CASE_E;
        else if (CHAIN.second inside {CMD_READ_KD, CMD_READ_DATA}) sel_case = CASE_D;
        else if (CHAIN.second inside {CMD_WRITE_KD, CMD_WRITE_DATA} && CHAIN.key_length == '0) begin
          sel_case = CASE_A;
        end else if (CHAIN.second == CMD_WRITE_DATA) sel_case = CASE_D;
      end
      CMD_READ_CKD: if (CHAIN.second == CMD_READ_CKD) sel_case = CASE_D;
      CMD_WRITE_CKD: if (CHAIN.second == CMD_WRITE_CKD) sel_case = CASE_B;
      CMD_SEARCH_HA_EQ: begin
        if (CHAIN.second == CMD_READ_R0) sel_case = CASE_D;
        else if (CHAIN.second == CMD_WRITE_R0) sel_case = CASE_A;
      end
      CMD_READ_COUNT: if (CHAIN.second == CMD_SEARCH_KEY) sel_case = CASE_C;
      default: sel_case = CASE_NONE;
    endcase
  end

  // deadlines of the case in force
  always_comb begin
    need_cmd = 1'b0;
    need_data = 1'b0;
    cmd_lim = `US_CNT_MAX;
    stat_lim = `US_CNT_MAX;
    data_lim = `US_CNT_MAX;
    case (CASE_SEL)
      CASE_A: begin
        need_cmd = 1'b1;
        need_data = 1'b1;
        cmd_lim = `A_CMD_US;
        stat_lim = `A_STAT_US;
        data_lim = `A_DATA_US;
      end
      CASE_B: begin
        need_cmd = 1'b1;
        need_data = 1'b1;
        cmd_lim = `B_CMD_US;
        stat_lim = `B_STAT_US;
        data_lim = `B_DATA_US;
      end
      CASE_C: begin
        need_data = 1'b1;
        stat_lim = `C_STAT_US;
        data_lim = `C_DATA_US;
      end
      CASE_D: stat_lim = `D_STAT_US;
      CASE_E: begin
        need_cmd = 1'b1;
        cmd_lim = `E_CMD_US;
      end
      default: need_cmd = 1'b0;
    endcase
  end

  assign bcd = CASE_SEL inside {CASE_B, CASE_C, CASE_D};
  assign in_window = (us_r >= `POSTPONE_LO_US) && (us_r <= `POSTPONE_HI_US);
  assign cmd_rise = CHAN.cmd_tag && !cmd_d_r && (state_r == ST_RUN);
  // a held-back tag is released in the first cycle that the counter holds 86, one cycle after the tick
  assign cmd_det = (cmd_rise && !(bcd && in_window)) ||
                   (cmd_pend_r && us_r == `POSTPONE_AT_US);
  // overrun on the first microsecond past a deadline with the event still missing
  assign late = (state_r == ST_RUN) && !REF_RISE && (
                (need_cmd && !cmd_got_r && us_r > cmd_lim) ||
                (CASE_SEL != CASE_E && !stat_seen_r && us_r > stat_lim) ||
                (need_data && !data_seen_r && us_r > data_lim));
  assign all_met = (!need_cmd || cmd_got_r) && (CASE_SEL == CASE_E ? 1'b1 : stat_seen_r) &&
                   (!need_data || data_seen_r) && (!bcd || cmd_pend_r == 1'b0);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (REF_RISE && sel_case != CASE_NONE) state_nxt = ST_RUN;
      ST_RUN: begin
        if (REF_RISE) state_nxt = (sel_case != CASE_NONE) ? ST_RUN : ST_IDLE;
        else if (late) state_nxt = ST_OVR;
        else if (all_met) state_nxt = ST_IDLE;
      end
      ST_OVR: if (REF_RISE && sel_case != CASE_NONE) state_nxt = ST_RUN;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  always_ff @(posedge CLK) begin
    if (RST) ACTIVE <= 1'b0;
    else ACTIVE <= (state_nxt == ST_RUN);
  end

  // microsecond counter, saturating so a stalled chain never wraps into a pass
  always_ff @(posedge CLK) begin
    if (RST || REF_RISE) us_r <= '0;
    else if (tick && state_r == ST_RUN && us_r != `US_CNT_MAX) us_r <= us_r + 9'h001;
  end

  // case in force; an early tag in case E falls back to case D
  always_ff @(posedge CLK) begin
    if (RST) CASE_SEL <= CASE_NONE;
    else if (REF_RISE) CASE_SEL <= sel_case;
    else if (CASE_SEL == CASE_E && cmd_rise && us_r < `E_EARLY_US) CASE_SEL <= CASE_D;
  end

  always_ff @(posedge CLK) begin
    if (RST) cmd_d_r <= 1'b0;
    else cmd_d_r <= CHAN.cmd_tag;
  end

  always_ff @(posedge CLK) begin
    if (RST || REF_RISE) begin
      cmd_got_r <= 1'b0;
      stat_seen_r <= 1'b0;
      data_seen_r <= 1'b0;
    end else if (state_r == ST_RUN) begin
      if (cmd_rise) cmd_got_r <= 1'b1;
      if (CHAN.status_accept) stat_seen_r <= 1'b1;
      if (CHAN.data_ready) data_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || REF_RISE) cmd_pend_r <= 1'b0;
    else if (cmd_rise && bcd && in_window) cmd_pend_r <= 1'b1;
    else if (cmd_det) cmd_pend_r <= 1'b0;
  end

  always_ff @(posedge CLK) begin
    if (RST) CMD_DETECT <= 1'b0;
    else CMD_DETECT <= cmd_det;
  end

  always_ff @(posedge CLK) begin
    if (RST || REF_RISE) cmd_seen_r <= 1'b0;
    else if (cmd_det) cmd_seen_r <= 1'b1;
  end

  // counting nine ticks guarantees a full 8 us whatever the detection phase
  always_ff @(posedge CLK) begin
    if (RST || REF_RISE || cmd_det) hold_r <= 4'h0;
    else if (cmd_seen_r && tick && hold_r <= `STATUS_HOLD_US) hold_r <= hold_r + 4'h1;
  end

  always_ff @(posedge CLK) begin
    if (RST || REF_RISE) STATUS_ENABLE <= 1'b0;
    else STATUS_ENABLE <= cmd_seen_r && !cmd_det && (!bcd || hold_r > `STATUS_HOLD_US);
  end

  always_ff @(posedge CLK) begin
    if (RST) OVERRUN <= 1'b0;
    else OVERRUN <= late;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_REF_RESTART: assert property (REF_RISE && sel_case != CASE_NONE |=> us_r == '0 && ACTIVE)
    else $error("reference edge did not restart the timer");
  AST_LATE_OVERRUN: assert property (late |=> OVERRUN && state_r == ST_OVR)
    else $error("missed deadline did not post overrun");
  AST_E_FALLBACK: assert property (CASE_SEL == CASE_E && cmd_rise && us_r < `E_EARLY_US && !REF_RISE |=> CASE_SEL == CASE_D)
    else $error("early tag in case E did not fall back");
  AST_POSTPONE: assert property (cmd_det && bcd |-> !in_window)
    else $error("command detected inside the postponement window");
  AST_PEND_RELEASE: assert property (cmd_pend_r && us_r == `POSTPONE_AT_US && !REF_RISE |=> CMD_DETECT)
    else $error("postponed detection not released at 86 us");
  AST_STATUS_HOLD: assert property (cmd_det && bcd && !REF_RISE |=> !STATUS_ENABLE [*8])
    else $error("status enabled too soon after detection");
  AST_STATUS_GATE: assert property (STATUS_ENABLE && bcd |-> hold_r > `STATUS_HOLD_US)
    else $error("status enabled before hold elapsed");
  AST_SEL_A: assert property (REF_RISE && CHAIN.first == CMD_SEARCH_ID && CHAIN.second == CMD_WRITE_DATA &&
                              CHAIN.key_length == '0 |=> CASE_SEL == CASE_A)
    else $error("search id to write data with zero key length not case A");
  AST_SEL_KL: assert property (REF_RISE && CHAIN.first == CMD_SEARCH_ID && CHAIN.second == CMD_WRITE_DATA &&
                               CHAIN.key_length != '0 |=> CASE_SEL == CASE_D)
    else $error("search id to write data with key not case D");
  AST_SEL_HA: assert property (REF_RISE && CHAIN.first == CMD_SEARCH_HA_EQ && CHAIN.second == CMD_WRITE_R0
                               |=> CASE_SEL == CASE_A)
    else $error("home address search to write record zero not case A");
  AST_SEL_READ: assert property (REF_RISE && CHAIN.first == CMD_READ_ID && CHAIN.second == CMD_READ_KD
                                 |=> CASE_SEL == CASE_D)
    else $error("read id to read key data not case D");
  AST_US_STEP: assert property (tick && state_r == ST_RUN && !REF_RISE && us_r != `US_CNT_MAX
                                |=> us_r == $past(us_r) + 9'h001)
    else $error("microsecond counter did not advance");

  COV_OVERRUN: cover property (OVERRUN);
  COV_CLEAN: cover property (ACTIVE && all_met && !late);
  COV_POSTPONED: cover property (cmd_pend_r ##1 CMD_DETECT);
  COV_FALLBACK: cover property (CASE_SEL == CASE_E ##1 CASE_SEL == CASE_D);

endmodule : chain_overrun_checker

// file: tb/chan_model.sv
// host channel model: command tag level, status acceptance and first data pulses at set microseconds
// assumes go comes with the reference edge; 10'h3ff means the event never comes
`timescale 1ns/10ps

module chan_model
  import chain_ovr_pkg::*;
#(
  parameter int DIV = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // schedule
  input wire logic go,
  input wire logic [9:0] cmd_us,
  input wire logic [9:0] stat_us,
  input wire logic [9:0] data_us,
  // channel events
  output chan_ev_s ev
);
  int cnt_r;

  always_ff @(posedge clk) begin
    if (rst || go) begin
      cnt_r <= 0;
      ev <= '0;
    end else begin
      cnt_r <= cnt_r + 1;
      // the tag is a level and stays up until the next chain
      if (cnt_r == cmd_us * DIV) begin
        ev.cmd_tag <= 1'b1;
      end
      ev.status_accept <= (cnt_r == stat_us * DIV);
      ev.data_ready <= (cnt_r == data_us * DIV);
    end
  end
endmodule : chan_model

// file: tb/chaining_overrun_checker_tb.sv
// self-checking bench for the chaining overrun checker
// assumes a divider of 2 cycles per microsecond so long chains stay short
`timescale 1ns/10ps

module chaining_overrun_checker_tb import chain_ovr_pkg::*;;
  localparam int DIV = 2;
  localparam logic [9:0] NEVER = 10'h3ff;
  logic clk, rst, ref_rise, go;
  chain_req_s chain;
  chan_ev_s chan;
  logic [9:0] cmd_us, stat_us, data_us;
  logic cmd_detect, status_enable, overrun, active, act_first, act_end;
  chain_case_e case_sel, case_first, case_end;
  int error_cnt, samples_checked, ovr_t, det_t, sen_t;

  chain_overrun_checker #(.US_DIV(DIV)) DUT (
    .CLK(clk), .RST(rst), .REF_RISE(ref_rise), .CHAIN(chain), .CHAN(chan),
    .CMD_DETECT(cmd_detect), .STATUS_ENABLE(status_enable), .OVERRUN(overrun),
    .CASE_SEL(case_sel), .ACTIVE(active)
  );
  chan_model #(.DIV(DIV)) host (
    .clk(clk), .rst(rst), .go(go), .cmd_us(cmd_us), .stat_us(stat_us),
    .data_us(data_us), .ev(chan)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic chk_case(input chain_case_e got, input chain_case_e exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_case

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // times in microseconds after the reference edge; -1 means never seen
  task automatic chk_time(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_time

  // one chain: reference edge, then watch outputs for n_us microseconds
  task automatic run(input cmd_code_e f, input cmd_code_e s, input logic [7:0] kl,
                     input logic [9:0] c, input logic [9:0] st, input logic [9:0] d, input int n_us);
    ovr_t = -1;
    det_t = -1;
    sen_t = -1;
    @(posedge clk);
    ref_rise <= 1'b1;
    go <= 1'b1;
    chain <= '{f, s, kl};
    cmd_us <= c;
    stat_us <= st;
    data_us <= d;
    @(posedge clk);
    ref_rise <= 1'b0;
    go <= 1'b0;
    #1;
    case_first = case_sel;
    act_first = active;
    for (int cyc = 2; cyc <= n_us * DIV; cyc++) begin
      @(posedge clk);
      #1;
      if (overrun === 1'b1 && ovr_t < 0) ovr_t = cyc / DIV;
      if (cmd_detect === 1'b1 && det_t < 0) det_t = cyc / DIV;
      if (status_enable === 1'b1 && sen_t < 0) sen_t = cyc / DIV;
    end
    case_end = case_sel;
    act_end = active;
  endtask : run

  task automatic dec(input cmd_code_e f, input cmd_code_e s, input logic [7:0] kl, input chain_case_e exp);
    run(f, s, kl, NEVER, NEVER, NEVER, 1);
    chk_case(case_first, exp);
    chk_bit(act_first, exp != CASE_NONE);
  endtask : dec

  ////////////////////////////////////////
  task automatic t_decode();
    dec(CMD_SEARCH_ID, CMD_WRITE_KD, 8'h00, CASE_A);
    dec(CMD_SEARCH_ID, CMD_WRITE_DATA, 8'h00, CASE_A);
    dec(CMD_SEARCH_ID, CMD_WRITE_DATA, 8'h05, CASE_D);
    dec(CMD_SEARCH_HA_EQ, CMD_READ_R0, 8'h00, CASE_D);
    dec(CMD_SEARCH_HA_EQ, CMD_WRITE_R0, 8'h00, CASE_A);
    dec(CMD_READ_ID, CMD_READ_KD, 8'h00, CASE_D);
    dec(CMD_SEARCH_ID, CMD_READ_DATA, 8'h00, CASE_D);
    dec(CMD_WRITE_CKD, CMD_WRITE_CKD, 8'h00, CASE_B);
    dec(CMD_READ_COUNT, CMD_SEARCH_KEY, 8'h00, CASE_C);
    dec(CMD_SEARCH_KEY, CMD_READ_CKD, 8'h00, CASE_E);
    dec(CMD_OTHER, CMD_OTHER, 8'h00, CASE_NONE);
    $display("decode test done");
  endtask : t_decode

  task automatic t_case_a();
    run(CMD_SEARCH_ID, CMD_WRITE_DATA, 8'h00, 10'd60, 10'd90, 10'd130, 150);
    chk_time(ovr_t, -1, -1);
    chk_bit(act_end, 1'b0);
    run(CMD_SEARCH_ID, CMD_WRITE_DATA, 8'h00, 10'd60, 10'd90, NEVER, 150);
    chk_time(ovr_t, 134, 136);
    // a second reference edge mid-run must restart every deadline
    run(CMD_SEARCH_ID, CMD_WRITE_DATA, 8'h00, NEVER, NEVER, NEVER, 40);
    run(CMD_SEARCH_ID, CMD_WRITE_DATA, 8'h00, NEVER, NEVER, NEVER, 100);
    chk_time(ovr_t, 70, 72);
    $display("case A test done");
  endtask : t_case_a

  task automatic t_case_b();
    run(CMD_WRITE_CKD, CMD_WRITE_CKD, 8'h00, 10'd60, NEVER, 10'd100, 150);
    chk_time(ovr_t, 88, 90);
    run(CMD_WRITE_CKD, CMD_WRITE_CKD, 8'h00, 10'd80, 10'd85, 10'd100, 150);
    chk_time(ovr_t, 79, 81);
    $display("case B test done");
  endtask : t_case_b

  task automatic t_case_c();
    run(CMD_READ_COUNT, CMD_SEARCH_KEY, 8'h00, 10'd80, 10'd110, 10'd120, 140);
    chk_time(det_t, 86, 87);
    chk_time(sen_t - det_t, 8, 10);
    chk_time(ovr_t, -1, -1);
    run(CMD_READ_COUNT, CMD_SEARCH_KEY, 8'h00, 10'd80, 10'd110, NEVER, 140);
    chk_time(ovr_t, 129, 131);
    $display("case C test done");
  endtask : t_case_c

  task automatic t_case_d();
    run(CMD_SEARCH_KEY, CMD_READ_DATA, 8'h00, 10'd30, NEVER, NEVER, 130);
    chk_time(ovr_t, 116, 118);
    $display("case D test done");
  endtask : t_case_d

  task automatic t_case_e();
    run(CMD_SEARCH_KEY, CMD_READ_CKD, 8'h00, 10'd50, 10'd100, NEVER, 130);
    chk_case(case_end, CASE_D);
    chk_time(ovr_t, -1, -1);
    run(CMD_SEARCH_KEY, CMD_READ_CKD, 8'h00, NEVER, NEVER, NEVER, 200);
    chk_time(ovr_t, 183, 185);
    $display("case E test done");
  endtask : t_case_e

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////
  // the whole run needs about 3000 cycles
  initial begin
    repeat (12000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    ref_rise = 1'b0;
    go = 1'b0;
    chain = '0;
    cmd_us = NEVER;
    stat_us = NEVER;
    data_us = NEVER;
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_case(case_sel, CASE_NONE);
    t_decode();
    t_case_a();
    t_case_b();
    t_case_c();
    t_case_d();
    t_case_e();
    print_verdict();
  end
endmodule : chaining_overrun_checker_tb
